// >>> hw/timer16_unit.sv
// 16-bit timer: capture, event counting, square wave and one-shot output
`timescale 1ns/10ps
module timer16_unit
  import timer16_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire ctrl_s cfg,
  input wire logic oneshot_sw_trigger,
  input wire logic [15:0] wr_data,
  input wire logic wr_match_a,
  input wire logic wr_match_b,
  input wire logic wrap_clear,
  input wire logic trigger_in_a,
  output logic [15:0] up_counter,
  output logic [15:0] match_capture_a,
  output logic [15:0] match_capture_b,
  output logic match_a_irq,
  output logic match_b_irq,
  output logic wrap_flag,
  output logic timer_out
);

  op_mode_e op_mode;
  logic [1:0] edge_sel;
  logic [7:0] div_ff;
  logic count_en;
  logic run;
  logic rise;
  logic fall;
  logic trig_hit;
  logic inv_hit;
  logic tick;
  logic capture_mode;
  logic match_a;
  logic match_b;
  logic clear_a;
  logic os_start;
  logic restart_cap;
  logic cap_a;
  logic cap_b;
  logic wrap_ev;
  logic b_pend_ff;
  logic wrap_hold_ff;
  logic first_a_ff;
  logic os_on;
  logic os_off;
  os_state_e os_ff;

  assign op_mode = op_mode_e'({cfg.op_mode_bit_hi, cfg.op_mode_bit_lo});
  assign edge_sel = {cfg.edge_sel_high, cfg.edge_sel_low};
  assign run = (op_mode != OP_STOP);

  // Divider gives the count clock as a one-cycle enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_ff <= DIV_RESET;
    end else if (!run || count_en) begin
      div_ff <= DIV_RESET;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  always_comb begin
    unique case (cfg.prescale_edge_cfg)
      PRE_MAIN: count_en = 1'b1;
      PRE_DIV4: count_en = (div_ff == DIV4_LAST);
      default: count_en = (div_ff == DIV256_LAST);
    endcase
  end

  // Event counting samples on every main clock, capture on the count clock
  level_twice_filter u_filter (
    .clk(clk),
    .resetn(resetn),
    .sample_en(cfg.event_count ? 1'b1 : count_en),
    .enable(run),
    .level_in(trigger_in_a),
    .rise(rise),
    .fall(fall)
  );

  // Edge and match decode; the opposite edge exists for every select except both edges
  assign trig_hit = run && edge_hit(edge_sel, rise, fall);
  assign inv_hit = run && cfg.two_capture && (edge_sel != EDGE_BOTH) &&
                   edge_hit({1'b0, ~edge_sel[0]}, rise, fall);
  assign tick = run && (cfg.event_count ? trig_hit : count_en);
  assign capture_mode = !cfg.event_count && !cfg.oneshot_enable && (op_mode != OP_CLEAR_MATCH);
  assign match_a = tick && (up_counter == match_capture_a);
  assign match_b = tick && (up_counter == match_capture_b);
  assign clear_a = match_a && (op_mode == OP_CLEAR_MATCH);
  assign os_start = cfg.oneshot_enable && run && (os_ff == OS_IDLE) &&
                    (oneshot_sw_trigger || trig_hit);
  assign restart_cap = capture_mode && (op_mode == OP_RESTART) && trig_hit;
  assign cap_b = capture_mode && trig_hit;
  assign cap_a = capture_mode && (op_mode != OP_RESTART) && inv_hit;
  assign wrap_ev = tick && (up_counter == COUNT_MAX);
  assign os_on = (os_ff == OS_WAIT) && (match_a || match_b);
  assign os_off = (os_ff == OS_ON) && (first_a_ff ? match_b : match_a);

  // Counter: stop clears, trigger restarts, match clears, else count up
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_counter <= COUNT_ZERO;
    end else if (!run) begin
      up_counter <= COUNT_ZERO;
    end else if (os_start || restart_cap) begin
      up_counter <= COUNT_ZERO;
    end else if (tick) begin
      up_counter <= clear_a ? COUNT_ZERO : up_counter + COUNT_ONE;
    end
  end

  // Capture wins over a software write landing in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      match_capture_a <= COUNT_ZERO;
      match_capture_b <= COUNT_ZERO;
    end else begin
      if (cap_a) begin
        match_capture_a <= up_counter;
      end else if (wr_match_a) begin
        match_capture_a <= wr_data;
      end
      if (cap_b) begin
        match_capture_b <= up_counter;
      end else if (wr_match_b) begin
        match_capture_b <= wr_data;
      end
    end
  end

  // Capture interrupt is held back to the next count tick
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      b_pend_ff <= 1'b0;
      match_b_irq <= 1'b0;
      match_a_irq <= 1'b0;
    end else begin
      b_pend_ff <= cap_b || (b_pend_ff && !count_en);
      match_b_irq <= (b_pend_ff && count_en) || (cfg.oneshot_enable && match_b);
      match_a_irq <= clear_a || (cfg.oneshot_enable && match_a);
    end
  end

  // Wrap flag: new wraps beat a clear; hold re-sets until the counter reaches one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrap_hold_ff <= 1'b0;
      wrap_flag <= 1'b0;
    end else begin
      wrap_hold_ff <= wrap_ev || (wrap_hold_ff && !tick && run);
      wrap_flag <= wrap_ev || wrap_hold_ff || (wrap_flag && !wrap_clear);
    end
  end

  // One-shot sequencer; the first match reached turns the pulse on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      os_ff <= OS_IDLE;
      first_a_ff <= 1'b0;
    end else if (!run || !cfg.oneshot_enable) begin
      os_ff <= OS_IDLE;
    end else begin
      unique case (os_ff)
        OS_IDLE: begin
          if (os_start) begin
            os_ff <= OS_WAIT;
          end
        end
        OS_WAIT: begin
          if (os_on) begin
            os_ff <= OS_ON;
            first_a_ff <= match_a;
          end
        end
        OS_ON: begin
          if (os_off) begin
            os_ff <= OS_IDLE;
          end
        end
        default: os_ff <= OS_IDLE;
      endcase
    end
  end

  // Pin drive; with the enable bit low the pin rests low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_out <= 1'b0;
    end else if (!cfg.output_enable_bit) begin
      timer_out <= 1'b0;
    end else if (cfg.oneshot_enable) begin
      if (os_on) begin
        timer_out <= 1'b1;
      end else if (os_off) begin
        timer_out <= 1'b0;
      end
    end else if (cfg.toggle_on_match_a && clear_a) begin
      timer_out <= !timer_out;
    end
  end

  property p_square_clear;
    @(posedge clk) disable iff (!resetn)
      (run && !cfg.event_count && !cfg.oneshot_enable && op_mode == OP_CLEAR_MATCH
       && count_en && up_counter == match_capture_a) |=> (up_counter == COUNT_ZERO);
  endproperty
  a_square_clear: assert property (p_square_clear)
    else $error("counter not cleared on compare match");

  property p_event_inc;
    @(posedge clk) disable iff (!resetn)
      (cfg.event_count && !cfg.oneshot_enable && trig_hit && up_counter != match_capture_a)
      |=> (up_counter == $past(up_counter) + COUNT_ONE);
  endproperty
  a_event_inc: assert property (p_event_inc)
    else $error("event edge did not add one");

  property p_event_match;
    @(posedge clk) disable iff (!resetn)
      (cfg.event_count && op_mode == OP_CLEAR_MATCH && trig_hit
       && up_counter == match_capture_a) |=> (up_counter == COUNT_ZERO && match_a_irq);
  endproperty
  a_event_match: assert property (p_event_match)
    else $error("event match missing clear or interrupt");

  property p_wrap_set;
    @(posedge clk) disable iff (!resetn)
      (tick && up_counter == COUNT_MAX) |=> (wrap_flag && up_counter == COUNT_ZERO);
  endproperty
  a_wrap_set: assert property (p_wrap_set)
    else $error("rollover did not set wrap flag");

  // Watches the counter itself, so a broken hold or a clear that wins is caught
  property p_wrap_resist;
    @(posedge clk) disable iff (!resetn)
      ($past(tick) && $past(up_counter) == COUNT_MAX) |=> wrap_flag;
  endproperty
  a_wrap_resist: assert property (p_wrap_resist)
    else $error("early wrap clear took effect");

  property p_restart_cap;
    @(posedge clk) disable iff (!resetn)
      restart_cap |=> (up_counter == COUNT_ZERO && match_capture_b == $past(up_counter));
  endproperty
  a_restart_cap: assert property (p_restart_cap)
    else $error("restart edge did not capture and clear");

  property p_capture_irq;
    @(posedge clk) disable iff (!resetn)
      (cap_b && cfg.prescale_edge_cfg == PRE_MAIN) |=> match_capture_b == $past(up_counter)
      ##1 match_b_irq;
  endproperty
  a_capture_irq: assert property (p_capture_irq)
    else $error("capture or its delayed interrupt missing");

  property p_sw_start;
    @(posedge clk) disable iff (!resetn)
      (cfg.oneshot_enable && run && os_ff == OS_IDLE && oneshot_sw_trigger)
      |=> (up_counter == COUNT_ZERO && os_ff == OS_WAIT);
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("software trigger did not clear and start");

  property p_square_toggle;
    @(posedge clk) disable iff (!resetn)
      (clear_a && !cfg.oneshot_enable && cfg.output_enable_bit && cfg.toggle_on_match_a)
      |=> (timer_out != $past(timer_out));
  endproperty
  a_square_toggle: assert property (p_square_toggle)
    else $error("timer output did not invert on match");

endmodule : timer16_unit

// >>> hw/timer16_pkg.sv
// Package with modes, constants, control struct and edge decode for the 16-bit timer
package timer16_pkg;

  typedef enum logic [1:0] {
    OP_STOP = 2'b00,
    OP_RESTART = 2'b01,
    OP_FREE = 2'b10,
    OP_CLEAR_MATCH = 2'b11
  } op_mode_e;

  typedef enum logic [1:0] {
    OS_IDLE = 2'b00,
    OS_WAIT = 2'b01,
    OS_ON = 2'b10
  } os_state_e;

  // Prescaler selections and terminal counts of the divider
  localparam logic [1:0] PRE_MAIN = 2'b00;
  localparam logic [1:0] PRE_DIV4 = 2'b01;
  localparam logic [7:0] DIV4_LAST = 8'h03;
  localparam logic [7:0] DIV256_LAST = 8'hFF;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // Edge select encodings {edge_sel_high, edge_sel_low}
  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b11;

  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // Software-held configuration
  typedef struct packed {
    logic op_mode_bit_hi;
    logic op_mode_bit_lo;
    logic edge_sel_high;
    logic edge_sel_low;
    logic [1:0] prescale_edge_cfg;
    logic event_count;
    logic two_capture;
    logic oneshot_enable;
    logic output_enable_bit;
    logic toggle_on_match_a;
  } ctrl_s;

  // True when a filtered edge matches the selected edge kind
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    edge_hit = (rise && (sel == EDGE_RISE || sel == EDGE_BOTH)) ||
               (fall && (sel == EDGE_FALL || sel == EDGE_BOTH));
  endfunction : edge_hit

endpackage : timer16_pkg

// >>> hw/level_twice_filter.sv
// Two-sample glitch filter producing rise and fall pulses
`timescale 1ns/10ps
module level_twice_filter
  import timer16_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sample_en,
  input wire logic enable,
  input wire logic level_in,
  output logic rise,
  output logic fall
);

  logic samp_ff;
  logic stable_ff;

  // A level is accepted only when two consecutive samples agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      samp_ff <= 1'b0;
      stable_ff <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else if (!enable) begin
      // Track level while stopped so re-enable does not see a false edge
      samp_ff <= level_in;
      stable_ff <= level_in;
      rise <= 1'b0;
      fall <= 1'b0;
    end else if (sample_en) begin
      samp_ff <= level_in;
      rise <= (samp_ff == level_in) && level_in && !stable_ff;
      fall <= (samp_ff == level_in) && !level_in && stable_ff;
      if (samp_ff == level_in) begin
        stable_ff <= level_in;
      end
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
    end
  end

  property p_single_sample_no_edge;
    @(posedge clk) disable iff (!resetn)
      (enable && sample_en && level_in && !samp_ff) |=> !rise;
  endproperty
  a_single_sample_no_edge: assert property (p_single_sample_no_edge)
    else $error("rise after a single high sample");

endmodule : level_twice_filter

// >>> tb/pin_partner.sv
// Far-side pin model: trigger source and output pin watcher
`timescale 1ns/10ps
module pin_partner (
  input wire logic clk,
  input wire logic timer_out,
  output logic trigger_in_a
);
  int out_edges;
  logic out_prev;
  // Pin driven low from time zero, a floating trigger would read as noise
  initial begin
    trigger_in_a = 1'b0;
    out_edges = 0;
    out_prev = 1'b0;
  end
  // Counts output pin changes so toggles can be tied to match pulses
  always @(posedge clk) begin
    if (timer_out !== out_prev) begin
      out_edges <= out_edges + 1;
    end
    out_prev <= timer_out;
  end
  // Holds a level for some cycles; caller must stand at a falling edge
  task automatic drive(input logic lvl, input int cycles);
    trigger_in_a = lvl;
    repeat (cycles) @(negedge clk);
  endtask : drive
endmodule : pin_partner

// >>> tb/testbench.sv
// Self-checking bench for the 16-bit timer unit
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
  $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
  import timer16_pkg::*;
  logic clk, resetn, oneshot_sw_trigger, wr_match_a, wr_match_b, wrap_clear, trigger_in_a;
  logic match_a_irq, match_b_irq, wrap_flag, timer_out;
  logic [15:0] wr_data, up_counter, match_capture_a, match_capture_b;
  ctrl_s cfg;
  int fails, total_checks, irq_a_n, irq_b_n, n;

  timer16_unit uut (.clk(clk), .resetn(resetn), .cfg(cfg),
    .oneshot_sw_trigger(oneshot_sw_trigger), .wr_data(wr_data), .wr_match_a(wr_match_a),
    .wr_match_b(wr_match_b), .wrap_clear(wrap_clear), .trigger_in_a(trigger_in_a),
    .up_counter(up_counter), .match_capture_a(match_capture_a),
    .match_capture_b(match_capture_b), .match_a_irq(match_a_irq),
    .match_b_irq(match_b_irq), .wrap_flag(wrap_flag), .timer_out(timer_out));
  pin_partner partner (.clk(clk), .timer_out(timer_out), .trigger_in_a(trigger_in_a));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Interrupt pulses last one cycle, so tally them rather than poll
  always @(posedge clk) begin
    if (match_a_irq === 1'b1) irq_a_n++;
    if (match_b_irq === 1'b1) irq_b_n++;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  function automatic ctrl_s mk(input logic [1:0] op, input logic [1:0] es, input logic [4:0] b);
    ctrl_s c;
    c = '0;
    {c.op_mode_bit_hi, c.op_mode_bit_lo} = op;
    {c.edge_sel_high, c.edge_sel_low} = es;
    {c.event_count, c.two_capture, c.oneshot_enable, c.output_enable_bit,
      c.toggle_on_match_a} = b;
    mk = c;
  endfunction : mk
  // Stop, set control bits, load both match registers, then start
  task automatic setup(input ctrl_s c, input logic [15:0] a, input logic [15:0] b);
    ctrl_s s;
    s = c;
    {s.op_mode_bit_hi, s.op_mode_bit_lo} = 2'h0;
    cfg = s;
    cyc(2);
    wr_data = a;
    wr_match_a = 1'b1;
    cyc(1);
    wr_data = b;
    wr_match_a = 1'b0;
    wr_match_b = 1'b1;
    cyc(1);
    wr_match_b = 1'b0;
    irq_a_n = 0;
    irq_b_n = 0;
    partner.out_edges = 0;
    cfg = c;
    cyc(1);
  endtask : setup
  // Cycles until the output pin changes, bounded
  task automatic wait_out(output int k);
    logic lvl;
    lvl = timer_out;
    k = 0;
    while (timer_out === lvl && k < 300) begin
      cyc(1);
      k++;
    end
    `CHK("output change", 1'b1, timer_out !== lvl)
  endtask : wait_out

  task automatic square_wave();
    setup(mk(OP_CLEAR_MATCH, EDGE_RISE, 5'h03), 16'h0002, 16'h0001);
    wait_out(n);
    `CHK("count at toggle", 16'h0000, up_counter)
    wait_out(n);
    `CHK("half period", 3, n)
    `CHK("irq per toggle", partner.out_edges, irq_a_n)
  endtask : square_wave
  // Each edge kind counted, glitch ignored, match clears with interrupt
  task automatic event_count();
    logic [1:0] sels [4] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH, 2'h2};
    logic [15:0] exp_n [4] = '{16'h0002, 16'h0002, 16'h0004, 16'h0000};
    foreach (sels[i]) begin
      setup(mk(OP_CLEAR_MATCH, sels[i], 5'h10), 16'h0005, 16'h0001);
      repeat (2) begin
        partner.drive(1'b1, 3);
        partner.drive(1'b0, 3);
      end
      `CHK("event count", exp_n[i], up_counter)
    end
    setup(mk(OP_CLEAR_MATCH, EDGE_RISE, 5'h10), 16'h0003, 16'h0001);
    partner.drive(1'b1, 1);
    partner.drive(1'b0, 4);
    `CHK("glitch count", 16'h0000, up_counter)
    repeat (3) begin
      partner.drive(1'b1, 3);
      partner.drive(1'b0, 3);
    end
    `CHK("count at match", 16'h0003, up_counter)
    partner.drive(1'b1, 3);
    partner.drive(1'b0, 3);
    `CHK("cleared count", 16'h0000, up_counter)
    `CHK("match irq", 1, irq_a_n)
  endtask : event_count
  task automatic restart_capture();
    setup(mk(OP_RESTART, EDGE_RISE, 5'h00), 16'h0001, 16'h0001);
    cyc(20);
    partner.drive(1'b1, 6);
    `CHK("restart", 1'b1, match_capture_b > 16'h000F && up_counter < 16'h0008)
    partner.drive(1'b0, 6);
    `CHK("capture irq", 1, irq_b_n)
  endtask : restart_capture
  // Count clock at a quarter and a 256th rate; capture irq waits for the next count tick
  task automatic prescaled_capture();
    ctrl_s c;
    c = mk(OP_RESTART, EDGE_RISE, 5'h00);
    c.prescale_edge_cfg = PRE_DIV4;
    setup(c, 16'h0001, 16'h0001);
    cyc(20);
    partner.drive(1'b1, 9);
    `CHK("slow capture", 16'h0007, match_capture_b)
    `CHK("slow restart", 16'h0000, up_counter)
    `CHK("irq before tick", 0, irq_b_n)
    partner.drive(1'b0, 6);
    `CHK("irq at tick", 1, irq_b_n)
    `CHK("count after restart", 16'h0002, up_counter)
    c.prescale_edge_cfg = 2'h2;
    setup(c, 16'h0001, 16'h0001);
    cyc(600);
    `CHK("slowest count", 16'h0002, up_counter)
  endtask : prescaled_capture
  task automatic two_capture();
    setup(mk(OP_FREE, EDGE_RISE, 5'h08), 16'h0001, 16'h0001);
    cyc(5);
    partner.drive(1'b1, 10);
    partner.drive(1'b0, 6);
    `CHK("pulse width", 16'h000A, match_capture_a - match_capture_b)
    partner.drive(1'b1, 1);
    partner.drive(1'b0, 5);
    `CHK("capture irq", 1, irq_b_n)
  endtask : two_capture
  // One-shot by software or pin edge; width is the gap between matches
  task automatic one_shot(input logic [15:0] a, input logic [15:0] b, input logic ext);
    setup(mk(OP_FREE, EDGE_RISE, 5'h06), a, b);
    if (ext) begin
      partner.drive(1'b1, 4);
      partner.drive(1'b0, 2);
    end else begin
      oneshot_sw_trigger = 1'b1;
      cyc(1);
      oneshot_sw_trigger = 1'b0;
    end
    wait_out(n);
    `CHK("pulse on", 1'b1, timer_out)
    wait_out(n);
    `CHK("pulse width", 3, n)
    cyc(5);
    `CHK("runs on", 1'b1, up_counter > 16'h0006)
  endtask : one_shot
  task automatic wrap();
    setup(mk(OP_FREE, EDGE_RISE, 5'h00), 16'h0001, 16'h0001);
    n = 0;
    while (up_counter !== 16'hFFFF && n < 70000) begin
      cyc(1);
      n++;
    end
    `CHK("reached max", 16'hFFFF, up_counter)
    cyc(1);
    `CHK("wrapped count", 16'h0000, up_counter)
    `CHK("wrap set", 1'b1, wrap_flag)
    // Clear while the counter still reads zero must not take
    wrap_clear = 1'b1;
    cyc(1);
    wrap_clear = 1'b0;
    `CHK("early clear", 1'b1, wrap_flag)
    cyc(3);
    `CHK("wrap sticky", 1'b1, wrap_flag)
    wrap_clear = 1'b1;
    cyc(1);
    wrap_clear = 1'b0;
    `CHK("wrap cleared", 1'b0, wrap_flag)
  endtask : wrap

  task automatic summarize();
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // Watchdog sized above the roughly 67000 cycles the tests take
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    summarize();
  end
  initial begin
    fails = 0;
    total_checks = 0;
    resetn = 1'b0;
    cfg = '0;
    oneshot_sw_trigger = 1'b0;
    wr_data = 16'h0000;
    wr_match_a = 1'b0;
    wr_match_b = 1'b0;
    wrap_clear = 1'b0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    cyc(1);
    square_wave();
    event_count();
    restart_capture();
    prescaled_capture();
    two_capture();
    one_shot(16'h0006, 16'h0003, 1'b0);
    one_shot(16'h0003, 16'h0006, 1'b0);
    one_shot(16'h0006, 16'h0003, 1'b1);
    wrap();
    summarize();
  end
endmodule : testbench
